// file: include/asal_pkg.sv
/*
  Shared constants for the alarm sticky and alert logic: sizes, register
  offsets, field positions, reset values, mode and loop state codes, timing.
  Assumes a 100 MHz core clock and a 32-bit APB register bus.
*/
package asal_pkg;

  // Sizes of the alarm map
  localparam int NUM_REF       = 2;   // Reference monitors
  localparam int NUM_LOOP      = 3;   // Index 0 is the system loop, then channel loops
  localparam int ALM_PER_REF   = 3;
  localparam int ALM_PER_LOOP  = 2;
  localparam int LOOP_ALM_BASE = NUM_REF * ALM_PER_REF;
  localparam int NUM_ALM       = LOOP_ALM_BASE + NUM_LOOP * ALM_PER_LOOP;
  localparam int NUM_BLK       = NUM_REF + NUM_LOOP;
  localparam int NUM_GPIO      = 4;
  localparam int LS_W          = 4;   // Width of one loop state code

  // Alarm slot inside its block
  localparam int ALM_FREQ = 0;
  localparam int ALM_LOS  = 1;
  localparam int ALM_ACT  = 2;
  localparam int ALM_HOLD = 0;
  localparam int ALM_LOCK = 1;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_LIVE       = 8'h04;
  localparam logic [7:0] OFF_STICKY     = 8'h08;
  localparam logic [7:0] OFF_BLK_STICKY = 8'h0c;
  localparam logic [7:0] OFF_ALERT_EN   = 8'h10;
  localparam logic [7:0] OFF_LOOP_STATE = 8'h14;
  localparam logic [7:0] OFF_GPIO_CFG   = 8'h18;
  localparam logic [7:0] OFF_GPIO_END   = 8'h28;
  localparam logic [7:0] OFF_PIN_STATE  = 8'h28;

  // Field positions and reset values
  localparam int CTRL_GLB_EN_BIT = 0;
  localparam int ALERT_BLK_LSB   = 16;
  localparam int CFG_MODE_LSB    = 0;
  localparam int CFG_INV_BIT     = 2;
  localparam int CFG_SEL_LSB     = 4;
  localparam int CFG_W           = 8;
  localparam logic [CFG_W-1:0]   CFG_RST      = 8'h00;
  localparam logic [NUM_ALM-1:0] ALERT_EN_RST = 12'h000;
  localparam logic [NUM_BLK-1:0] BLK_EN_RST   = 5'h00;

  // Pin release timing: longest time rounds down to whole cycles
  localparam int CLK_MHZ          = 100;
  localparam int NEG_TIME_US      = 200;
  localparam int NEG_CYCLES_DFLT  = NEG_TIME_US * CLK_MHZ;
  localparam int NEG_CNT_W        = 15;

  typedef enum logic [1:0] {
    MODE_OFF    = 2'h0,
    MODE_LIVE   = 2'h1,
    MODE_STICKY = 2'h2,
    MODE_ALERT  = 2'h3
  } asal_mode_t;

  // Loop state machine codes, one-hot
  typedef enum logic [LS_W-1:0] {
    LS_FREERUN  = 4'h1,
    LS_LOCKING  = 4'h2,
    LS_LOCKED   = 4'h4,
    LS_HOLDOVER = 4'h8
  } asal_loop_state_t;

  // Block that owns a given alarm index
  function automatic logic [2:0] alm_block(input int idx);
    if (idx < LOOP_ALM_BASE) begin
      alm_block = 3'(idx / ALM_PER_REF);
    end else begin
      alm_block = 3'(NUM_REF + (idx - LOOP_ALM_BASE) / ALM_PER_LOOP);
    end
  endfunction

endpackage

// file: include/asal_alarm_if.sv
/*
  Carrier between the register side and the sticky bank.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface asal_alarm_if import asal_pkg::*; ();
  logic [NUM_ALM-1:0] live;
  logic [NUM_ALM-1:0] clr;
  logic [NUM_ALM-1:0] sticky;
  logic [NUM_BLK-1:0] blk_clr;
  logic [NUM_BLK-1:0] blk_sticky;
  logic               glb_en;

  modport bank (input live, clr, blk_clr, glb_en, output sticky, blk_sticky);
  modport ctl  (output live, clr, blk_clr, glb_en, input sticky, blk_sticky);
endinterface

// file: logic/asal_sticky_bank.sv
/*
  Sticky bank: change detection on every live alarm, individual and block
  sticky bits with write-one clears.
  Assumes clears arrive as one-cycle pulses from the register side.
*/
`timescale 1ns/1ps
module asal_sticky_bank
  import asal_pkg::*;
(
  input  wire logic   clk,  // Core clock
  input  wire logic   rst,  // Asynchronous reset, active high
  asal_alarm_if.bank  al    // Live in, stickies out
);

  logic [NUM_ALM-1:0] live_q_r;
  logic [NUM_ALM-1:0] sticky_r;
  logic [NUM_ALM-1:0] sticky_nxt;
  logic [NUM_ALM-1:0] chg_w;
  logic [NUM_ALM-1:0] race_w;
  logic [NUM_BLK-1:0] blk_r;
  logic [NUM_BLK-1:0] blk_nxt;
  logic [NUM_BLK-1:0] blk_set_w;

  // Either edge of a live alarm counts; the global enable masks new events
  assign chg_w      = (al.live ^ live_q_r) & {NUM_ALM{al.glb_en}};
  assign race_w     = chg_w & al.clr;
  assign sticky_nxt = (sticky_r & ~al.clr) | chg_w;

  // Block sticky follows any individual set; set beats the block clear too
  always_comb begin
    blk_set_w = '0;
    for (int i = 0; i < NUM_ALM; i++) begin
      if (chg_w[i]) begin
        blk_set_w[alm_block(i)] = 1'b1;
      end
    end
  end
  assign blk_nxt = (blk_r & ~al.blk_clr) | blk_set_w;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      live_q_r <= '0;
      sticky_r <= '0;
      blk_r    <= '0;
    end else begin
      live_q_r <= al.live;
      sticky_r <= sticky_nxt;
      blk_r    <= blk_nxt;
    end
  end

  assign al.sticky     = sticky_r;
  assign al.blk_sticky = blk_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_sticky_on_change: assert property ((chg_w != '0) |=> ((sticky_r & $past(chg_w)) == $past(chg_w)))
    else $error("sticky bit missed a live change");
  a_sticky_holds: assert property ((sticky_r & ~al.clr) != '0 |=>
      (($past(sticky_r) & ~$past(al.clr) & ~sticky_r) == '0))
    else $error("sticky bit dropped without a clear");
  a_set_wins_clear: assert property ((race_w != '0) |=> ((sticky_r & $past(race_w)) == $past(race_w)))
    else $error("change lost against a same-cycle clear");
  a_glb_gate_off: assert property (!al.glb_en |=> ((sticky_r & ~$past(sticky_r)) == '0))
    else $error("sticky raised while alarms disabled");
  a_blk_follows: assert property ((chg_w[0] || chg_w[1] || chg_w[2]) |=> blk_r[0])
    else $error("block sticky not raised by its alarm");

  c_race_seen: cover property (race_w != '0);

endmodule

// file: logic/asal_top.sv
/*
  Alarm sticky and alert logic: live alarm build-up from reference monitors
  and loop states, APB register file, alarm and alert pin drivers.
  Assumes all alarm and loop state inputs are synchronous to CLK.
*/
//
// Behaviour
// - Live bits read back the present alarm level, never latched.
// - Any live change, rising or falling, sets its sticky until cleared.
// - A pin tied to one alarm shows live or sticky state, optionally inverted.
// - The alert pin is built from sticky bits only.
// - Each reference monitor gives frequency, loss and activity alarms.
// - Holdover live is high while the loop sits in holdover.
// - Locked live needs the loop locked and the analog loop locked.
// - Loop stickies fire on state entry; loop state is readable.
// - System loop and every channel loop carry holdover and locked alarms.
// - Each alarm has live, sticky, clear and pin-routing configuration.
// - Host may clear any single sticky or any mix of them at once.
// - Each reference monitor has a block sticky set by its alarms.
// - Each loop has a block sticky, its clear, controls and a state field.
// - Alarm pins stay active until alarm and block stickies are cleared.
// - Pin negation after clearing may lag by up to 200 microseconds.
// - A global enable gates sticky events from every alarm source; live bits and live pins are not gated.
// - Per-alarm enables choose alert sources; alert polarity is invertible.
// - Alert is the OR of enabled stickies, active high by default.
// - A loss-of-signal pin follows the live alarm directly.
`timescale 1ns/1ps
module asal_top
  import asal_pkg::*;
#(
  parameter int NEG_CYCLES = NEG_CYCLES_DFLT  // Pin release interval in cycles
)(
  input  wire logic                     CLK,          // 100 MHz core clock
  input  wire logic                     RST,          // Asynchronous reset, active high
  input  wire logic                     PSEL,         // APB select
  input  wire logic                     PENABLE,      // APB access phase
  input  wire logic                     PWRITE,       // APB direction, high for write
  input  wire logic [7:0]               PADDR,        // APB byte address
  input  wire logic [31:0]              PWDATA,       // APB write data
  output logic      [31:0]              PRDATA,       // APB read data
  output logic                          PREADY,       // APB ready
  output logic                          PSLVERR,      // APB error on unmapped address
  input  wire logic [NUM_REF-1:0]       REF_FREQ_ALM, // Frequency offset limit exceeded
  input  wire logic [NUM_REF-1:0]       REF_LOS_ALM,  // Loss of signal
  input  wire logic [NUM_REF-1:0]       REF_ACT_ALM,  // Activity alarm
  input  wire logic [NUM_LOOP*LS_W-1:0] LOOP_STATE,   // One-hot loop states, system loop low
  input  wire logic                     ANALOG_LOCK,  // System analog loop locked
  output logic      [NUM_GPIO-1:0]      GPIO_O,       // Alarm pin levels
  output logic      [NUM_GPIO-1:0]      GPIO_OE       // Pin driven when high
);

  asal_alarm_if al ();

  logic [NUM_ALM-1:0]            live_w;
  logic [NUM_ALM-1:0]            stk_ext_w;
  logic [NUM_ALM-1:0]            lock_mask_w;
  logic                          ctrl_glb_r;
  logic [NUM_ALM-1:0]            alert_en_r;
  logic [NUM_BLK-1:0]            blk_en_r;
  logic [NUM_GPIO-1:0][CFG_W-1:0] gpio_cfg_r;
  logic [NUM_GPIO-1:0]           pin_act_r;
  logic [NUM_GPIO-1:0]           pin_act_nxt;
  logic [NUM_GPIO-1:0]           raw_w;
  logic [NUM_GPIO-1:0]           inv_w;
  logic [NUM_GPIO-1:0][3:0]      sel_w;
  asal_mode_t                    mode_w [NUM_GPIO];
  logic [NEG_CNT_W-1:0]          cnt_r;
  logic                          tick_w;
  logic                          alert_w;
  logic [31:0]                   prdata_r;
  logic                          pready_r;
  logic                          pslverr_r;
  logic [NUM_GPIO-1:0]           gpio_o_r;
  logic [NUM_GPIO-1:0]           gpio_oe_r;

  // Live alarm map: reference monitors first, then system and channel loops
  for (genvar r = 0; r < NUM_REF; r++) begin : g_ref
    assign live_w[r*ALM_PER_REF+ALM_FREQ] = REF_FREQ_ALM[r];
    assign live_w[r*ALM_PER_REF+ALM_LOS]  = REF_LOS_ALM[r];
    assign live_w[r*ALM_PER_REF+ALM_ACT]  = REF_ACT_ALM[r];
  end
  for (genvar l = 0; l < NUM_LOOP; l++) begin : g_loop
    localparam int HI = LOOP_ALM_BASE + l*ALM_PER_LOOP + ALM_HOLD;
    localparam int LI = LOOP_ALM_BASE + l*ALM_PER_LOOP + ALM_LOCK;
    assign live_w[HI] = LOOP_STATE[l*LS_W +: LS_W] == LS_HOLDOVER;
    assign live_w[LI] = (LOOP_STATE[l*LS_W +: LS_W] == LS_LOCKED)
                        && ANALOG_LOCK;
    assign lock_mask_w[HI] = 1'b0;
    assign lock_mask_w[LI] = 1'b1;
  end
  for (genvar r = 0; r < LOOP_ALM_BASE; r++) begin : g_refmask
    assign lock_mask_w[r] = 1'b0;
  end

  // Sticky bank; live goes in unlatched, global enable masks new events
  assign al.live   = live_w;
  assign al.glb_en = ctrl_glb_r;

  asal_sticky_bank u_bank (
    .clk (CLK),
    .rst (RST),
    .al  (al.bank)
  );

  // APB decode: no wait state, read data and ready come from flops loaded in the setup cycle
  logic       setup_w;
  logic       acc_w;
  logic       wr_w;
  logic       gpio_hit_w;
  logic [7:0] gpio_off_w;
  logic [1:0] gpio_idx_w;
  logic       addr_ok_w;
  logic [31:0] rdata_w;
  logic [NUM_ALM-1:0] clr_w;

  assign setup_w    = PSEL && !PENABLE;
  assign acc_w      = PSEL && PENABLE && pready_r;
  assign wr_w       = acc_w && PWRITE && !pslverr_r;
  assign gpio_off_w = PADDR - OFF_GPIO_CFG;
  assign gpio_idx_w = gpio_off_w[3:2];
  assign gpio_hit_w = (PADDR >= OFF_GPIO_CFG) && (PADDR < OFF_GPIO_END);
  assign addr_ok_w  = (PADDR[1:0] == 2'h0) &&
                      ((PADDR <= OFF_LOOP_STATE) || gpio_hit_w || (PADDR == OFF_PIN_STATE));

  // Read selection; live is taken at the setup cycle of the read
  assign rdata_w =
    !addr_ok_w                 ? 32'h0 :
    (PADDR == OFF_CTRL)        ? {31'h0, ctrl_glb_r} :
    (PADDR == OFF_LIVE)        ? {20'h0, live_w} :
    (PADDR == OFF_STICKY)      ? {20'h0, al.sticky} :
    (PADDR == OFF_BLK_STICKY)  ? {27'h0, al.blk_sticky} :
    (PADDR == OFF_ALERT_EN)    ? {11'h0, blk_en_r, 4'h0, alert_en_r} :
    (PADDR == OFF_LOOP_STATE)  ? {20'h0, LOOP_STATE} :
    gpio_hit_w                 ? {24'h0, gpio_cfg_r[gpio_idx_w]} :
                                 {28'h0, gpio_o_r};

  // Write-one-to-clear pulses, one cycle at the write edge
  assign clr_w      = (wr_w && PADDR == OFF_STICKY) ? PWDATA[NUM_ALM-1:0] : '0;
  assign al.clr     = clr_w;
  assign al.blk_clr = (wr_w && PADDR == OFF_BLK_STICKY) ? PWDATA[NUM_BLK-1:0] : '0;

  // Bus answer flops
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      prdata_r  <= 32'h0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup_w;
      pslverr_r <= setup_w && !addr_ok_w;
      prdata_r  <= setup_w ? rdata_w : prdata_r;
    end
  end

  // Control registers; writes to read-only words are ignored
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_glb_r <= 1'b0;
      alert_en_r <= ALERT_EN_RST;
      blk_en_r   <= BLK_EN_RST;
      gpio_cfg_r <= {NUM_GPIO{CFG_RST}};
    end else if (wr_w) begin
      if (PADDR == OFF_CTRL) begin
        ctrl_glb_r <= PWDATA[CTRL_GLB_EN_BIT];
      end
      if (PADDR == OFF_ALERT_EN) begin
        alert_en_r <= PWDATA[NUM_ALM-1:0];
        blk_en_r   <= PWDATA[ALERT_BLK_LSB +: NUM_BLK];
      end
      if (gpio_hit_w) begin
        gpio_cfg_r[gpio_idx_w] <= PWDATA[CFG_W-1:0];
      end
    end
  end

  // A sticky pin stays up while the alarm or its block sticky stands
  for (genvar i = 0; i < NUM_ALM; i++) begin : g_ext
    assign stk_ext_w[i] = al.sticky[i] | al.blk_sticky[alm_block(i)];
  end

  // Alert: OR of enabled stickies only, so the cause stays readable
  assign alert_w = |(al.sticky & alert_en_r) | |(al.blk_sticky & blk_en_r);

  // Per-pin source selection
  for (genvar g = 0; g < NUM_GPIO; g++) begin : g_pin
    logic sel_ok;
    assign mode_w[g] = asal_mode_t'(gpio_cfg_r[g][CFG_MODE_LSB +: 2]);
    assign sel_w[g]  = gpio_cfg_r[g][CFG_SEL_LSB +: 4];
    assign inv_w[g]  = gpio_cfg_r[g][CFG_INV_BIT];
    assign sel_ok    = sel_w[g] < 4'(NUM_ALM);
    assign raw_w[g]  =
      (mode_w[g] == MODE_LIVE)   ? sel_ok && live_w[sel_w[g]] :
      (mode_w[g] == MODE_STICKY) ? sel_ok && stk_ext_w[sel_w[g]] :
      (mode_w[g] == MODE_ALERT)  ? alert_w : 1'b0;
    // Asserts at once; sticky and alert pins release only on the next interval
    // tick, while a live pin follows its alarm with no hold
    assign pin_act_nxt[g] = raw_w[g] |
                            (pin_act_r[g] & ~tick_w & (mode_w[g] != MODE_LIVE));
  end

  // Release interval; a shared tick bounds negation lag to one interval,
  // which keeps pin chatter away from an edge-triggered interrupt
  assign tick_w = cnt_r == '0;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= tick_w ? NEG_CNT_W'(NEG_CYCLES - 1) : cnt_r - 1'b1;
    end
  end

  // Pin flops
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pin_act_r <= '0;
      gpio_o_r  <= '0;
      gpio_oe_r <= '0;
    end else begin
      pin_act_r <= pin_act_nxt;
      gpio_o_r  <= pin_act_nxt ^ inv_w;
      for (int g = 0; g < NUM_GPIO; g++) begin
        gpio_oe_r[g] <= mode_w[g] != MODE_OFF;
      end
    end
  end

  assign PRDATA  = prdata_r;
  assign PREADY  = pready_r;
  assign PSLVERR = pslverr_r;
  assign GPIO_O  = gpio_o_r;
  assign GPIO_OE = gpio_oe_r;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_live_read_now: assert property (setup_w && PADDR == OFF_LIVE |=>
      PRDATA[NUM_ALM-1:0] == $past(live_w))
    else $error("live read did not return present alarm level");
  a_lock_needs_analog: assert property (!ANALOG_LOCK |-> (live_w & lock_mask_w) == '0)
    else $error("locked live high while analog loop unlocked");
  a_loop_entry_sticky: assert property (ctrl_glb_r &&
      $rose(live_w[LOOP_ALM_BASE+ALM_HOLD]) |=> al.sticky[LOOP_ALM_BASE+ALM_HOLD])
    else $error("holdover entry did not raise sticky");
  a_alert_pin_level: assert property (mode_w[2] == MODE_ALERT && alert_w |=>
      GPIO_O[2] == !$past(inv_w[2]))
    else $error("alert pin not asserted for enabled sticky");
  a_alert_no_live: assert property (mode_w[2] == MODE_ALERT && al.sticky == '0 &&
      al.blk_sticky == '0 && !pin_act_r[2] |=> GPIO_O[2] == $past(inv_w[2]))
    else $error("alert pin raised without any sticky");
  a_blk_holds_pin: assert property (mode_w[1] == MODE_STICKY && sel_w[1] == 4'h0 &&
      al.blk_sticky[0] |=> GPIO_O[1] == !$past(inv_w[1]))
    else $error("pin released while block sticky stands");
  a_pin_neg_wait: assert property (mode_w[1] != MODE_LIVE && pin_act_r[1] &&
      !raw_w[1] && !tick_w |=> pin_act_r[1])
    else $error("pin released between interval ticks");
  a_live_pin_direct: assert property (mode_w[0] == MODE_LIVE |=>
      GPIO_O[0] == ($past(raw_w[0]) ^ $past(inv_w[0])))
    else $error("live pin did not follow its alarm");
  a_cnt_bound: assert property (cnt_r < NEG_CYCLES)
    else $error("release interval counter out of range");
  // Bits whose live level moved in the write cycle are allowed to stay set
  a_clear_takes: assert property (clr_w != '0 |=>
      (al.sticky & $past(clr_w) & ~($past(live_w) ^ $past(live_w, 2))) == '0)
    else $error("sticky clear had no effect");
  a_apb_one_wait: assert property (setup_w |=> PREADY ##1 !PREADY)
    else $error("bus answer not one cycle after setup");

  c_alert_fires: cover property (mode_w[2] == MODE_ALERT && $rose(pin_act_r[2]));
  c_sticky_clear: cover property (clr_w != '0);
  c_pin_release: cover property ($fell(pin_act_r[0]));
  c_los_follow: cover property (mode_w[0] == MODE_LIVE && $rose(raw_w[0]));

endmodule

// file: bench/asal_host_model.sv
/*
  Host model: an APB master that reads alarm status and clears stickies.
  Assumes one clock shared with the device; the bench timeout ends hangs.
*/
`timescale 1ns/1ps
module asal_host_model (
  input  wire logic        clk,     // Core clock
  output logic             psel,    // APB select
  output logic             penable, // APB access phase
  output logic             pwrite,  // APB direction
  output logic [7:0]       paddr,   // APB byte address
  output logic [31:0]      pwdata,  // APB write data
  input  wire logic [31:0] prdata,  // APB read data
  input  wire logic        pready,  // APB ready
  input  wire logic        pslverr  // APB error
);
  // Bus idle from time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // One transfer; the request stands until the rising edge at which ready is
  // seen high, and data and error are taken at that same edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Alarm service: individual bits first, so they cannot re-arm the block bit
  task automatic service;
    logic [31:0] q;
    logic        e;
    xfer(1'b1, 8'h08, 32'h0000_0fff, q, e);
    xfer(1'b1, 8'h0c, 32'h0000_001f, q, e);
  endtask
endmodule

// file: bench/testbench.sv
/*
  Testbench for the alarm sticky and alert logic: alarm inputs, loop states,
  register access through the host model, pin levels.
  Assumes the short pin release interval set below.
*/
`timescale 1ns/1ps
module testbench import asal_pkg::*; ();
  localparam int NEGC = 20;
  logic                     clk = 1'b0;
  logic                     rst = 1'b1;
  logic                     psel, penable, pwrite, pready, pslverr;
  logic [7:0]               paddr;
  logic [31:0]              pwdata, prdata, q;
  logic [NUM_REF-1:0]       ref_freq = '0, ref_los = '0, ref_act = '0;
  logic [NUM_LOOP*LS_W-1:0] loop_state = 12'h111, ls;
  logic                     analog_lock = 1'b1;
  logic [NUM_GPIO-1:0]      gpio_o, gpio_oe;
  logic [5:0]               v;
  int                       n_checks = 0, n_mismatch = 0, cycles = 0;

  // 100 MHz clock
  always #5 clk = ~clk;

  asal_top #(.NEG_CYCLES(NEGC)) DUT (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .REF_FREQ_ALM(ref_freq), .REF_LOS_ALM(ref_los),
    .REF_ACT_ALM(ref_act), .LOOP_STATE(loop_state), .ANALOG_LOCK(analog_lock),
    .GPIO_O(gpio_o), .GPIO_OE(gpio_oe));

  asal_host_model host (
    .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    host.xfer(1'b0, a, 32'h0, d, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    host.xfer(1'b1, a, d, r, e);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(d, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Pins may lag on release by up to one interval, so wait bounded
  task automatic pin_wait(input logic [3:0] exp);
    for (int i = 0; i < NEGC + 3 && gpio_o !== exp; i++) @(posedge clk);
    check({28'h0, gpio_o}, {28'h0, exp});
  endtask

  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  initial begin
    logic e;
    cyc(20);
    rst <= 1'b0;
    // Reset values and an unmapped word
    rdchk(OFF_CTRL, 32'h0);
    rdchk(OFF_ALERT_EN, 32'h0);
    rdchk(OFF_GPIO_CFG, 32'h0);
    rdchk(OFF_STICKY, 32'h0);
    host.xfer(1'b0, 8'h2c, 32'h0, q, e);
    check({31'h0, e}, 32'h1);
    check(q, 32'h0);
    // Unaligned write is refused and leaves the control word alone
    host.xfer(1'b1, 8'h01, 32'h1, q, e);
    check({31'h0, e}, 32'h1);
    rdchk(OFF_CTRL, 32'h0);
    // Disabled: live follows, no sticky
    ref_freq <= 2'b01;
    cyc(3);
    rdchk(OFF_LIVE, 32'h1);
    rdchk(OFF_STICKY, 32'h0);
    ref_freq <= 2'b00;
    wr(OFF_CTRL, 32'h1);
    rdchk(OFF_CTRL, 32'h1);
    // Each reference alarm, rising then falling
    for (int i = 0; i < 6; i++) begin
      v = 6'(1 << i);
      {ref_freq, ref_los, ref_act} <= {v[3], v[0], v[4], v[1], v[5], v[2]};
      cyc(3);
      rdchk(OFF_LIVE, 32'(v));
      rdchk(OFF_STICKY, 32'(v));
      rdchk(OFF_BLK_STICKY, 32'(1 << (i / 3)));
      host.service();
      rdchk(OFF_STICKY, 32'h0);
      {ref_freq, ref_los, ref_act} <= '0;
      cyc(3);
      rdchk(OFF_STICKY, 32'(v));
      host.service();
    end
    // A live change in the clear's own write cycle must keep its sticky
    fork
      wr(OFF_STICKY, 32'hfff);
      begin
        cyc(2);
        ref_act <= 2'b01;
      end
    join
    rdchk(OFF_STICKY, 32'h4);
    ref_act <= 2'b00;
    cyc(3);
    host.service();
    // Loop alarms for the system loop and each channel loop
    for (int l = 0; l < 3; l++) begin
      ls = 12'h111;
      ls[l*4+:4] = LS_HOLDOVER;
      loop_state <= ls;
      cyc(3);
      rdchk(OFF_LIVE, 32'(1 << (6 + 2 * l)));
      rdchk(OFF_LOOP_STATE, 32'(ls));
      rd(OFF_STICKY, q);
      check({31'h0, q[6+2*l]}, 32'h1);
      rd(OFF_BLK_STICKY, q);
      check({31'h0, q[2+l]}, 32'h1);
      ls[l*4+:4] = LS_LOCKED;
      loop_state <= ls;
      cyc(3);
      rdchk(OFF_LIVE, 32'(1 << (7 + 2 * l)));
      analog_lock <= 1'b0;
      cyc(3);
      rdchk(OFF_LIVE, 32'h0);
      analog_lock <= 1'b1;
    end
    loop_state <= 12'h111;
    cyc(3);
    host.service();
    // Pins: live on loss of ref 0, inverted sticky, alert and inverted alert
    wr(OFF_GPIO_CFG, 32'h11);
    wr(OFF_GPIO_CFG + 8'h04, 32'h06);
    wr(OFF_GPIO_CFG + 8'h08, 32'h03);
    wr(OFF_GPIO_CFG + 8'h0c, 32'h07);
    wr(OFF_ALERT_EN, 32'h1);
    check({28'h0, gpio_oe}, 32'hf);
    pin_wait(4'b1010);
    ref_los <= 2'b01;
    pin_wait(4'b1001);
    ref_los <= 2'b00;
    cyc(2);
    check({28'h0, gpio_o}, 32'h8);
    ref_freq <= 2'b01;
    pin_wait(4'b0100);
    ref_freq <= 2'b00;
    cyc(3);
    rdchk(OFF_PIN_STATE, 32'h4);
    wr(OFF_STICKY, 32'hfff);
    cyc(NEGC + 3);
    check({31'h0, gpio_o[1]}, 32'h0);
    wr(OFF_BLK_STICKY, 32'h1f);
    pin_wait(4'b1010);
    end_sim();
  end
endmodule
